// File: rtl/pcr_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH

// register indices; byte address is four times the index
`define PCR_IDX_DEV        8'ha8
`define PCR_IDX_PERI       8'haa
`define PCR_IDX_STAT       8'hb0
`define PCR_IDX_SVC        8'hb1

`define PCR_DEV_RST        32'h0000_0000
`define PCR_PERI_RST       32'h4000_0000

// device setup word fields
`define PCR_REF_RATE_MSB   7
`define PCR_REF_RATE_LSB   5
`define PCR_WDT_EN_BIT     4
`define PCR_WDT_INT_MSB    3
`define PCR_WDT_INT_LSB    2
`define PCR_WDT_SRC_BIT    1
`define PCR_WDT_ACT_BIT    0

// peripheral setup word fields
`define PCR_DITHER_DIS_BIT 30
`define PCR_CAP_MSB        25
`define PCR_CAP_LSB        22
`define PCR_CAP_EN_BIT     21

// status word fields
`define PCR_ST_FAULT_BIT   0
`define PCR_ST_HIZ_BIT     1
`define PCR_ST_RUN_BIT     2

`define PCR_REF_BASE_KHZ   11'h008

// timing
`define PCR_CLK_NS         20
`define PCR_MS_NS          1000000

// service periods in ms, gpio servicing then i2c servicing
`define PCR_GPIO_MS0       14'd100
`define PCR_GPIO_MS1       14'd200
`define PCR_GPIO_MS2       14'd500
`define PCR_GPIO_MS3       14'd1000
`define PCR_I2C_MS0        14'd1000
`define PCR_I2C_MS1        14'd2000
`define PCR_I2C_MS2        14'd5000
`define PCR_I2C_MS3        14'd10000

`endif

// File: rtl/pcr_pkg.sv
// types shared by the configuration bank and its watchdog
package pcr_pkg;

  typedef enum logic [0:0] {
    PCR_WDT_OFF = 1'b0,
    PCR_WDT_RUN = 1'b1
  } pcr_wdt_state_t;

  typedef struct packed {
    pcr_wdt_state_t st;
    logic [13:0]    cnt;
    logic           timeout;
    logic           running;
  } pcr_wdt_regs_t;

  typedef struct packed {
    logic [31:0] dev_word;
    logic [31:0] peri_word;
    logic        fault_seen;
    logic        hiz_latched;
    logic [15:0] ms_div;
    logic        ms_tick;
    logic        gpio_prev;
    logic        i2c_svc;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [10:0] ref_khz;
    logic        dither_en;
    logic [13:0] cap_ma;
    logic        cap_en;
  } pcr_top_regs_t;

endpackage : pcr_pkg

// File: rtl/pcr_top.sv
// configuration register bank with host watchdog, apb slave
// =========================================================
// Overview of operation
// R1 - reference rate code selects 8 to 1024 kHz
// R2 - watchdog runs only while its enable is set
// R3 - interval code picks period per service source
// R4 - source bit picks i2c or gpio servicing
// R5 - fault action: report only, or latch hi-z
// R6 - dither disable bit, resets set, dither off
// R7 - supply cap code maps to 0.125-8 A
// R8 - cap enforced only while cap enable set
// R9 - missed service within period raises watchdog fault
`timescale 1ns/1ps
`include "pcr_map.svh"
module pcr_top #(
  parameter int MS_CYCLES = `PCR_MS_NS / `PCR_CLK_NS
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        host_wdt_gpio,
  output logic [10:0]      reference_clock_khz,
  output logic             clock_dither_en,
  output logic [13:0]      supply_cap_ma,
  output logic             supply_cap_en,
  output logic             watchdog_fault,
  output logic             power_stage_hiz
);
  logic                  rst_meta;
  logic                  rst_n;
  pcr_pkg::pcr_top_regs_t s;
  pcr_pkg::pcr_top_regs_t next_s;
  logic [9:0]            word_idx;
  logic                  hit_dev;
  logic                  hit_peri;
  logic                  hit_stat;
  logic                  hit_svc;
  logic                  mapped;
  logic                  commit_wr;
  logic                  fault_evt;
  logic                  clr_fault;
  logic                  clr_hiz;
  logic [31:0]           stat_word;

  pcr_wdt_if wif ();

  // =========================================================
  // reset release
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // =========================================================
  // supply cap decode in milliamps
  function automatic logic [13:0] cap_decode(input logic [3:0] code);
    logic [13:0] ma;
    ma = 14'h0000;
    case (code) // R7
      4'h0:    ma = 14'd125;
      4'h1:    ma = 14'd250;
      4'h2:    ma = 14'd500;
      4'he:    ma = 14'd7000;
      4'hf:    ma = 14'd8000;
      // 1.0 A upward in half-amp steps
      default: ma = 14'd1000 + 14'(code - 4'h3) * 14'd500;
    endcase
    return ma;
  endfunction : cap_decode

  // =========================================================
  // address decode
  always_comb
  begin
    word_idx  = paddr[11:2];
    hit_dev   = (word_idx == {2'b00, `PCR_IDX_DEV});
    hit_peri  = (word_idx == {2'b00, `PCR_IDX_PERI});
    hit_stat  = (word_idx == {2'b00, `PCR_IDX_STAT});
    hit_svc   = (word_idx == {2'b00, `PCR_IDX_SVC});
    mapped    = hit_dev | hit_peri | hit_stat | hit_svc;
    // a write lands only on the edge where pready is seen high
    commit_wr = psel & penable & s.pready & pwrite & mapped;
    clr_fault = commit_wr & hit_stat & pwdata[`PCR_ST_FAULT_BIT];
    clr_hiz   = commit_wr & hit_stat & pwdata[`PCR_ST_HIZ_BIT];
    fault_evt = wif.timeout;
    stat_word = 32'h0000_0000;
    stat_word[`PCR_ST_FAULT_BIT] = s.fault_seen;
    stat_word[`PCR_ST_HIZ_BIT]   = s.hiz_latched;
    stat_word[`PCR_ST_RUN_BIT]   = wif.running;
  end

  // =========================================================
  // watchdog hookup
  assign wif.enable   = s.dev_word[`PCR_WDT_EN_BIT];
  assign wif.interval = s.dev_word[`PCR_WDT_INT_MSB:`PCR_WDT_INT_LSB];
  assign wif.source   = s.dev_word[`PCR_WDT_SRC_BIT];
  // gpio input is synchronous; a rising edge is one service
  assign wif.svc_gpio = host_wdt_gpio & ~s.gpio_prev; // R4
  assign wif.svc_i2c  = s.i2c_svc; // R4
  assign wif.ms_tick  = s.ms_tick;

  pcr_wdt u_wdt (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wif     (wif)
  );

  // =========================================================
  // next state
  always_comb
  begin
    next_s           = s;
    next_s.gpio_prev = host_wdt_gpio;
    next_s.i2c_svc   = 1'b0;
    next_s.ms_tick   = 1'b0;
    if (s.ms_div == 16'(MS_CYCLES - 1))
    begin
      next_s.ms_div  = 16'h0000;
      next_s.ms_tick = 1'b1;
    end
    else
    begin
      next_s.ms_div = s.ms_div + 16'h0001;
    end

    // apb: one wait state, then the answer
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    if (psel && penable && !s.pready)
    begin
      next_s.pready  = 1'b1;
      next_s.pslverr = ~mapped;
      next_s.prdata  = 32'h0000_0000;
      if (!pwrite)
      begin
        if (hit_dev)
          next_s.prdata = s.dev_word;
        else if (hit_peri)
          next_s.prdata = s.peri_word;
        else if (hit_stat)
          next_s.prdata = stat_word;
      end
    end
    if (commit_wr && hit_dev)
      next_s.dev_word = pwdata;
    if (commit_wr && hit_peri)
      next_s.peri_word = pwdata;
    if (commit_wr && hit_svc)
      next_s.i2c_svc = 1'b1;

    // fault sticky bits; a new fault beats a clear
    if (clr_fault)
      next_s.fault_seen = 1'b0;
    if (clr_hiz)
      next_s.hiz_latched = 1'b0;
    if (fault_evt)
    begin
      next_s.fault_seen = 1'b1; // R5
      if (s.dev_word[`PCR_WDT_ACT_BIT])
        next_s.hiz_latched = 1'b1; // R5
    end

    // decoded outputs
    next_s.ref_khz = `PCR_REF_BASE_KHZ
      << s.dev_word[`PCR_REF_RATE_MSB:`PCR_REF_RATE_LSB]; // R1
    next_s.dither_en = ~s.peri_word[`PCR_DITHER_DIS_BIT]; // R6
    next_s.cap_en    = s.peri_word[`PCR_CAP_EN_BIT]; // R8
    // a disabled cap reads as zero so nothing downstream limits
    next_s.cap_ma    = s.peri_word[`PCR_CAP_EN_BIT]
      ? cap_decode(s.peri_word[`PCR_CAP_MSB:`PCR_CAP_LSB]) // R7
      : 14'h0000; // R8
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s           <= '0;
      s.dev_word  <= `PCR_DEV_RST;
      s.peri_word <= `PCR_PERI_RST; // R6
    end
    else
    begin
      s <= next_s;
    end
  end

  assign prdata              = s.prdata;
  assign pready              = s.pready;
  assign pslverr             = s.pslverr;
  assign reference_clock_khz = s.ref_khz;
  assign clock_dither_en     = s.dither_en;
  assign supply_cap_ma       = s.cap_ma;
  assign supply_cap_en       = s.cap_en;
  assign watchdog_fault      = s.fault_seen;
  assign power_stage_hiz     = s.hiz_latched;

  // =========================================================
  // checks
  // the decode sits at zero in reset, so skip the release edges
  a_ref_rate: assert property (@(posedge clk_sys) disable iff (!rst_n) // R1
    $past(rst_n) |=> s.ref_khz == (`PCR_REF_BASE_KHZ
      << $past(s.dev_word[`PCR_REF_RATE_MSB:`PCR_REF_RATE_LSB])))
    else $error("reference rate decode wrong");
  a_dither_follow: assert property (@(posedge clk_sys) // R6
    disable iff (!rst_n)
    ##1 s.dither_en == !$past(s.peri_word[`PCR_DITHER_DIS_BIT]))
    else $error("dither output does not follow disable bit");
  a_cap_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n) // R8
    !s.peri_word[`PCR_CAP_EN_BIT] |=> s.cap_ma == 14'h0000 && !s.cap_en)
    else $error("cap active while disabled");
  a_cap_range: assert property (@(posedge clk_sys) disable iff (!rst_n) // R7
    s.peri_word[`PCR_CAP_EN_BIT]
      && s.peri_word[`PCR_CAP_MSB:`PCR_CAP_LSB] == 4'hf
      |=> s.cap_ma == 14'd8000)
    else $error("top cap code not 8 A");
  // software may legally clear hi-z on the very next edge
  a_hiz_latch: assert property (@(posedge clk_sys) disable iff (!rst_n) // R5
    fault_evt && s.dev_word[`PCR_WDT_ACT_BIT]
      |=> s.hiz_latched)
    else $error("fault did not latch hi-z");
  a_report_only: assert property (@(posedge clk_sys) disable iff (!rst_n) // R5
    fault_evt && !s.dev_word[`PCR_WDT_ACT_BIT] && !s.hiz_latched
      |=> s.fault_seen && !s.hiz_latched)
    else $error("report-only fault changed hi-z");
  a_set_wins: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
    fault_evt && clr_fault |=> s.fault_seen)
    else $error("fault lost against clear");
  a_apb_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    psel && penable && !s.pready |=> s.pready ##1 !s.pready)
    else $error("apb answer not one wait state");
  a_svc_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n) // R4
    commit_wr && hit_svc |=> wif.svc_i2c ##1 !wif.svc_i2c)
    else $error("i2c service pulse wrong");

endmodule : pcr_top

// File: rtl/pcr_wdt.sv
// host watchdog supervision timer
`timescale 1ns/1ps
`include "pcr_map.svh"
module pcr_wdt (
  input wire logic clk_sys,
  input wire logic rst_n,
  pcr_wdt_if.wdt   wif
);
  pcr_pkg::pcr_wdt_regs_t s;
  pcr_pkg::pcr_wdt_regs_t next_s;
  logic [13:0]            period;
  logic                   svc;

  assign wif.timeout = s.timeout;
  assign wif.running = s.running;

  // =========================================================
  // period and service selection
  always_comb
  begin
    case ({wif.source, wif.interval}) // R3
      3'b100:  period = `PCR_GPIO_MS0;
      3'b101:  period = `PCR_GPIO_MS1;
      3'b110:  period = `PCR_GPIO_MS2;
      3'b111:  period = `PCR_GPIO_MS3;
      3'b000:  period = `PCR_I2C_MS0;
      3'b001:  period = `PCR_I2C_MS1;
      3'b010:  period = `PCR_I2C_MS2;
      default: period = `PCR_I2C_MS3;
    endcase
    // service from the unselected path is ignored
    svc = wif.source ? wif.svc_gpio : wif.svc_i2c; // R4
  end

  // =========================================================
  // supervision
  always_comb
  begin
    next_s         = s;
    next_s.timeout = 1'b0;
    case (s.st)
      pcr_pkg::PCR_WDT_OFF:
      begin
        next_s.cnt = 14'h0000;
        if (wif.enable) // R2
        begin
          next_s.st = pcr_pkg::PCR_WDT_RUN;
        end
      end
      pcr_pkg::PCR_WDT_RUN:
      begin
        if (!wif.enable) // R2
        begin
          next_s.st  = pcr_pkg::PCR_WDT_OFF;
          next_s.cnt = 14'h0000;
        end
        else if (svc)
        begin
          next_s.cnt = 14'h0000; // R9
        end
        else if (wif.ms_tick)
        begin
          if (s.cnt >= period - 14'h0001)
          begin
            next_s.timeout = 1'b1; // R9
            next_s.cnt     = 14'h0000;
          end
          else
          begin
            next_s.cnt = s.cnt + 14'h0001;
          end
        end
      end
      default: next_s.st = pcr_pkg::PCR_WDT_OFF;
    endcase
    next_s.running = (next_s.st == pcr_pkg::PCR_WDT_RUN);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  a_off_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n) // R2
    !wif.enable |=> !s.timeout)
    else $error("watchdog fired while disabled");
  a_svc_restart: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
    (s.running && wif.enable && svc)
      |=> (s.cnt == 14'h0000) && !s.timeout)
    else $error("service did not restart the period");
  a_fire_at_end: assert property (@(posedge clk_sys) disable iff (!rst_n) // R3
    $rose(s.timeout) |-> $past(s.cnt) == $past(period) - 14'h0001)
    else $error("watchdog fired off its period");

endmodule : pcr_wdt

// File: rtl/pcr_wdt_if.sv
// signals between the register bank and the host watchdog
`timescale 1ns/1ps
interface pcr_wdt_if;
  logic       enable;
  logic [1:0] interval;
  logic       source;
  logic       svc_gpio;
  logic       svc_i2c;
  logic       ms_tick;
  logic       timeout;
  logic       running;

  modport bank (output enable, output interval, output source,
                output svc_gpio, output svc_i2c, output ms_tick,
                input timeout, input running);
  modport wdt  (input enable, input interval, input source,
                input svc_gpio, input svc_i2c, input ms_tick,
                output timeout, output running);
endinterface : pcr_wdt_if

// File: test/pcr_host_model.sv
// host microcontroller model servicing the watchdog over gpio
`timescale 1ns/1ps
module pcr_host_model #(
  parameter int GAP = 300
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic svc_en,
  output logic      host_wdt_gpio
);
  int cnt;
  // ==========================================
  // service pulse, two cycles high once per gap
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 0;
      host_wdt_gpio <= 1'b0;
    end
    else
    begin
      cnt <= (cnt >= GAP) ? 0 : cnt + 1;
      // gap kept well inside the shortest period
      host_wdt_gpio <= svc_en && (cnt < 2);
    end
  end
endmodule : pcr_host_model

// File: test/pcr_top_tb.sv
// self-checking bench for the configuration bank and watchdog
`timescale 1ns/1ps
`include "pcr_map.svh"
module pcr_top_tb;
  localparam int MS = 10;
  localparam logic [11:0] A_DEV  = {2'b00, `PCR_IDX_DEV, 2'b00};
  localparam logic [11:0] A_PERI = {2'b00, `PCR_IDX_PERI, 2'b00};
  localparam logic [11:0] A_STAT = {2'b00, `PCR_IDX_STAT, 2'b00};
  localparam logic [11:0] A_SVC  = {2'b00, `PCR_IDX_SVC, 2'b00};
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        gpio;
  logic        svc_en = 1'b0;
  logic [10:0] ref_khz;
  logic        dith;
  logic [13:0] cap_ma;
  logic        cap_en;
  logic        fault;
  logic        hiz;
  logic [31:0] rd;
  logic        er;
  int          num_errors = 0;
  int          tests_run = 0;
  int          cyc = 0;

  pcr_top #(.MS_CYCLES(MS)) u_pcr_top (.clk_sys(clk_sys), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_wdt_gpio(gpio), .reference_clock_khz(ref_khz),
    .clock_dither_en(dith), .supply_cap_ma(cap_ma), .supply_cap_en(cap_en),
    .watchdog_fault(fault), .power_stage_hiz(hiz));
  pcr_host_model #(.GAP(300)) u_pcr_host_model (.clk_sys(clk_sys),
    .rst_n(resetn), .svc_en(svc_en), .host_wdt_gpio(gpio));

  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end
  // ==================================
  // hang guard, well above the run time
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // answer taken at the rising edge that sees pready, then released
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no wait limit here: the hang guard ends a stuck transfer
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // decoded outputs follow one edge after the write lands
    repeat (2) @(negedge clk_sys);
  endtask : apb

  function automatic logic [13:0] cap_of(input int c);
    if (c < 3) return 14'(125 << c);
    if (c < 14) return 14'(1000 + (c - 3) * 500);
    return (c == 14) ? 14'd7000 : 14'd8000;
  endfunction : cap_of

  task automatic wait_fault(input int lim, output int n);
    n = 0;
    while (fault !== 1'b1 && n < lim)
    begin
      @(negedge clk_sys);
      n++;
    end
  endtask : wait_fault

  task automatic t_reset_map();
    apb(1'b0, A_DEV, 32'h0);
    chk("dev reset", `PCR_DEV_RST, rd);
    chk("mapped err", 32'h0, {31'h0, er});
    apb(1'b0, A_PERI, 32'h0);
    chk("peri reset", `PCR_PERI_RST, rd);
    chk("dither after reset", 32'h0, {31'h0, dith});
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    $display("test reset_map done");
  endtask : t_reset_map

  task automatic t_rate();
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, A_DEV, 32'(c << 5));
      chk("ref khz", 32'(8 << c), {21'h0, ref_khz});
    end
    $display("test rate done");
  endtask : t_rate

  task automatic t_cap();
    for (int c = 0; c < 16; c++)
    begin
      apb(1'b1, A_PERI, 32'(c << 22) | 32'h0020_0000);
      chk("cap ma", {18'h0, cap_of(c)}, {18'h0, cap_ma});
      chk("cap en", 32'h1, {31'h0, cap_en});
      chk("dither on", 32'h1, {31'h0, dith});
    end
    apb(1'b1, A_PERI, 32'h43c0_0000);
    chk("cap off ma", 32'h0, {18'h0, cap_ma});
    chk("cap off en", 32'h0, {31'h0, cap_en});
    chk("dither off", 32'h0, {31'h0, dith});
    $display("test cap done");
  endtask : t_cap

  task automatic t_wdt_gpio();
    int n;
    svc_en <= 1'b1;
    apb(1'b1, A_DEV, 32'h0000_0016);
    repeat (6000) @(negedge clk_sys);
    chk("serviced no fault", 32'h0, {31'h0, fault});
    svc_en <= 1'b0;
    wait_fault(3000, n);
    chk("missed fault", 32'h1, {31'h0, fault});
    chk("late enough", 32'h1, {31'h0, n >= 1600});
    chk("in time", 32'h1, {31'h0, n <= 2100});
    chk("report only", 32'h0, {31'h0, hiz});
    apb(1'b0, A_STAT, 32'h0);
    chk("status", 32'h5, rd);
    apb(1'b1, A_DEV, 32'h0);
    apb(1'b1, A_STAT, 32'h3);
    repeat (2500) @(negedge clk_sys);
    apb(1'b0, A_STAT, 32'h0);
    chk("disabled idle", 32'h0, rd);
    $display("test wdt_gpio done");
  endtask : t_wdt_gpio

  task automatic t_wdt_i2c();
    int n;
    svc_en <= 1'b1;
    apb(1'b1, A_DEV, 32'h0000_0011);
    repeat (6000) @(negedge clk_sys);
    apb(1'b1, A_SVC, 32'h0);
    chk("i2c kept", 32'h0, {31'h0, fault});
    wait_fault(12000, n);
    chk("gpio ignored", 32'h1, {31'h0, fault});
    chk("restart", 32'h1, {31'h0, n >= 9900});
    chk("in time", 32'h1, {31'h0, n <= 10100});
    chk("hiz latched", 32'h1, {31'h0, hiz});
    apb(1'b1, A_DEV, 32'h0);
    apb(1'b1, A_STAT, 32'h3);
    chk("hiz cleared", 32'h0, {31'h0, hiz});
    svc_en <= 1'b0;
    $display("test wdt_i2c done");
  endtask : t_wdt_i2c

  initial
  begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset_map();
    t_rate();
    t_cap();
    t_wdt_gpio();
    t_wdt_i2c();
    test_done();
  end
endmodule : pcr_top_tb
